// >>> logic/dsph_pkg.sv
// Constants, register map and state type for the deep sleep pin hold and wake block.
// What this block does
// - While in deep sleep every general-purpose pin holds the state it had just before entry.
// - A pin set as input at entry stays undriven for the whole of deep sleep.
// - A pin set as output at entry keeps driving its latch level from the moment of entry.
// - After a wake by calendar alarm, interrupt zero, watchdog or ultra-low-power wake, pins stay frozen even once code runs.
// - Wake resets the direction and latch registers, and firmware writes to them do not reach frozen pins.
// - Clearing the release bit, bit 0 of the control register, unfreezes the pins onto current direction and latch.
// - With the brown-out detector enabled, a supply drop in deep sleep releases the pins at once and clears both scratch registers.
// - An external reset pin event in deep sleep releases the pins and keeps both scratch registers.
// - Any of the six wake causes ends deep sleep with a power-on reset of the core.
// - A deep sleep exit other than by brown-out sets bit 3 of the watchdog control register, which only firmware clears.
// - Both wake source registers are cleared on every deep sleep entry.
// - Wake events are watched and logged only while fully in deep sleep.
// - An enabled calendar, interrupt zero, watchdog or ultra-low-power source asserted at entry vectors the core if enabled, otherwise entry is abandoned.
// - With several sources enabled only the first to assert is logged.
package dsph_pkg;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // Register offsets.
   localparam logic [3:0] OFS_CTRL     = 4'h0;
   localparam logic [3:0] OFS_WAKE_LO  = 4'h1;
   localparam logic [3:0] OFS_WAKE_HI  = 4'h2;
   localparam logic [3:0] OFS_WDT_CTRL = 4'h3;
   localparam logic [3:0] OFS_SCR0     = 4'h4;
   localparam logic [3:0] OFS_SCR1     = 4'h5;
   localparam logic [3:0] OFS_DIR      = 4'h6;
   localparam logic [3:0] OFS_LAT      = 4'h7;
   localparam logic [3:0] OFS_PIN_IN   = 4'h8;
   localparam logic [3:0] OFS_WAKE_EN  = 4'h9;
   localparam logic [3:0] OFS_IRQ_STAT = 4'hA;
   localparam logic [3:0] OFS_IRQ_MASK = 4'hB;

   // Control register fields, and the exit bit of the watchdog control register.
   localparam int unsigned CTRL_RELEASE_BIT = 0;
   localparam int unsigned CTRL_BOR_EN_BIT  = 1;
   localparam int unsigned CTRL_SLEEP_BIT   = 2;
   localparam int unsigned WDT_EXIT_BIT     = 3;

   // Wake source low fields; the high register holds interrupt zero in bit 0.
   localparam int unsigned WK_EXT_RESET = 0;
   localparam int unsigned WK_CALENDAR  = 1;
   localparam int unsigned WK_WATCHDOG  = 2;
   localparam int unsigned WK_ULP       = 3;
   localparam int unsigned WK_BROWNOUT  = 4;
   localparam int unsigned WKH_EXTERNAL_INTERRUPT_ZERO     = 0;

   // Wake enable fields, also the index into the gated source vector.
   localparam int unsigned EN_CALENDAR = 0;
   localparam int unsigned EN_EXTERNAL_INTERRUPT_ZERO     = 1;
   localparam int unsigned EN_WATCHDOG = 2;
   localparam int unsigned EN_ULP      = 3;

   // Interrupt status fields.
   localparam int unsigned IRQ_WAKE    = 0;
   localparam int unsigned IRQ_ABORT   = 1;
   localparam int unsigned IRQ_BOR     = 2;

   // Reset values.
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [7:0] DIR_RST     = 8'hFF;
   localparam logic [7:0] LAT_RST     = 8'h00;
   localparam logic [7:0] WAKE_EN_RST = 8'h00;
   localparam logic [7:0] ZERO_RST    = 8'h00;

   // Core power-on reset hold time.
   localparam int unsigned CLK_MHZ     = 250;
   localparam int unsigned POR_HOLD_NS = 100;
   localparam int unsigned POR_HOLD_CYC = (POR_HOLD_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_ENTER = 2'b01,
      ST_SLEEP = 2'b10,
      ST_WAKE  = 2'b11
   } dsph_state_type;

endpackage

// >>> logic/dsph_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
module dsph_sync #(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         ref_clk_i,  // Block clock.
   input  wire logic         arst_n_i,   // Asynchronous reset, active low.
   input  wire logic [W-1:0] async_i,    // Raw pin levels.
   output logic      [W-1:0] sync_o      // Filtered levels.
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stage1 <= RST_VAL;
         stage2 <= RST_VAL;
         stage3 <= RST_VAL;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   genvar b;
   generate
      for (b = 0; b < W; b++) begin : g_bit
         // A single-cycle glitch in stage two never reaches the output.
         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               sync_o[b] <= RST_VAL[b];
            end else if (stage2[b] == stage3[b]) begin
               sync_o[b] <= stage3[b];
            end
         end
      end
   endgenerate

endmodule // dsph_sync

// >>> logic/dsph_pin_hold.sv
// Per-pin selection between the frozen holding latches and the live direction and latch.
module dsph_pin_hold #(
   parameter int unsigned N_PINS = 8
) (
   input  wire logic              frozen_i,    // Pins held.
   input  wire logic [N_PINS-1:0] hold_dir_i,  // Direction captured at entry, 1 = input.
   input  wire logic [N_PINS-1:0] hold_lat_i,  // Level captured at entry.
   input  wire logic [N_PINS-1:0] dir_i,       // Live direction bits, 1 = input.
   input  wire logic [N_PINS-1:0] lat_i,       // Live output latch bits.
   output logic      [N_PINS-1:0] next_out_o,  // Next pin output level.
   output logic      [N_PINS-1:0] next_oe_o    // Next pin output enable.
);

   genvar p;
   generate
      for (p = 0; p < N_PINS; p++) begin : g_pin
         always_comb begin
            if (frozen_i) begin
               next_oe_o[p]  = ~hold_dir_i[p];
               next_out_o[p] = hold_lat_i[p] & ~hold_dir_i[p];
            end else begin
               next_oe_o[p]  = ~dir_i[p];
               next_out_o[p] = lat_i[p] & ~dir_i[p];
            end
         end
      end
   endgenerate

endmodule // dsph_pin_hold

// >>> logic/dsph_top.sv
// Deep sleep supervisor: pin freeze, wake logging, core reset and register port.
module dsph_top #(
   parameter int unsigned N_PINS = 8
) (
   input  wire logic                        ref_clk_i,       // 250 MHz clock.
   input  wire logic                        arst_n_i,        // Asynchronous reset, active low.
   input  wire logic [dsph_pkg::ADDR_W-1:0] reg_addr_i,      // Register address.
   input  wire logic [dsph_pkg::DATA_W-1:0] reg_wdata_i,     // Write data.
   input  wire logic                        reg_wr_i,        // Write strobe.
   input  wire logic                        reg_rd_i,        // Read strobe.
   output logic      [dsph_pkg::DATA_W-1:0] reg_rdata_o,     // Read data, one cycle later.
   input  wire logic                        ext_reset_n_i,   // External reset pin, low active.
   input  wire logic                        calendar_alarm_i,// Calendar alarm.
   input  wire logic                        ext_int_zero_i,  // External interrupt zero.
   input  wire logic                        watchdog_i,      // Deep sleep watchdog time-out.
   input  wire logic                        ulp_wake_i,      // Ultra-low-power wake.
   input  wire logic                        brownout_i,      // Supply below both thresholds.
   input  wire logic                        core_int_en_i,   // Core has the interrupt enabled.
   input  wire logic [N_PINS-1:0]           pin_in_i,        // Pin input levels.
   output logic      [N_PINS-1:0]           pin_out_o,       // Pin output levels.
   output logic      [N_PINS-1:0]           pin_oe_o,        // Pin output enables.
   output logic                             core_reset_o,    // Core power-on reset, high.
   output logic                             core_vector_o,   // Pulse: core takes wake vector.
   output logic                             entry_abort_o,   // Pulse: entry abandoned.
   output logic                             irq_o            // Level interrupt.
);

   if (N_PINS < 1 || N_PINS > dsph_pkg::DATA_W) begin : g_bad_pins
      $error("N_PINS must be 1 to DATA_W");
   end

   localparam int unsigned SRC_W = 6;
   localparam logic [5:0] SRC_RST = 6'h01;
   localparam logic [7:0] HOLD_MAX = 8'(dsph_pkg::POR_HOLD_CYC - 1);

   dsph_pkg::dsph_state_type state;
   dsph_pkg::dsph_state_type next_state;

   logic [SRC_W-1:0]  src_sync;
   logic [N_PINS-1:0] pin_sync;
   logic [7:0]        ctrl;
   logic [7:0]        wake_lo;
   logic [7:0]        wake_hi;
   logic [7:0]        wdt_ctrl;
   logic [7:0]        scr0;
   logic [7:0]        scr1;
   logic [7:0]        dir;
   logic [7:0]        lat;
   logic [7:0]        wake_en;
   logic [7:0]        irq_stat;
   logic [7:0]        irq_mask;
   logic [N_PINS-1:0] hold_dir;
   logic [N_PINS-1:0] hold_lat;
   logic [7:0]        hold_cnt;
   logic [N_PINS-1:0] next_out;
   logic [N_PINS-1:0] next_oe;
   logic [7:0]        next_rdata;
   logic [3:0]        gated;
   logic              ext_rst_evt;
   logic              bor_evt;
   logic              sleep_cmd;
   logic              release_clr;
   logic              entry_done;
   logic              wake_evt;
   logic              abort_evt;
   logic              frozen;

   dsph_sync #(
      .W       (SRC_W),
      .RST_VAL (SRC_RST)
   ) u_src_sync (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .async_i   ({brownout_i, ulp_wake_i, watchdog_i, ext_int_zero_i,
                   calendar_alarm_i, ext_reset_n_i}),
      .sync_o    (src_sync)
   );

   dsph_sync #(
      .W       (N_PINS),
      .RST_VAL ('0)
   ) u_pin_sync (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .async_i   (pin_in_i),
      .sync_o    (pin_sync)
   );

   assign gated[dsph_pkg::EN_CALENDAR] = src_sync[1] & wake_en[dsph_pkg::EN_CALENDAR];
   assign gated[dsph_pkg::EN_EXTERNAL_INTERRUPT_ZERO]     = src_sync[2] & wake_en[dsph_pkg::EN_EXTERNAL_INTERRUPT_ZERO];
   assign gated[dsph_pkg::EN_WATCHDOG] = src_sync[3] & wake_en[dsph_pkg::EN_WATCHDOG];
   assign gated[dsph_pkg::EN_ULP]      = src_sync[4] & wake_en[dsph_pkg::EN_ULP];
   assign ext_rst_evt = ~src_sync[0];
   assign bor_evt     = src_sync[5] & ctrl[dsph_pkg::CTRL_BOR_EN_BIT];

   assign sleep_cmd   = reg_wr_i && reg_addr_i == dsph_pkg::OFS_CTRL
                        && reg_wdata_i[dsph_pkg::CTRL_SLEEP_BIT];
   assign release_clr = reg_wr_i && reg_addr_i == dsph_pkg::OFS_CTRL
                        && !reg_wdata_i[dsph_pkg::CTRL_RELEASE_BIT];
   assign frozen      = ctrl[dsph_pkg::CTRL_RELEASE_BIT];
   // A gated source already high when entry is asked for stops the entry.
   assign abort_evt   = state == dsph_pkg::ST_RUN && sleep_cmd && (|gated);
   assign entry_done  = state == dsph_pkg::ST_ENTER;
   // Sources are looked at only once the entry cycle has finished.
   assign wake_evt    = state == dsph_pkg::ST_SLEEP
                        && (ext_rst_evt || bor_evt || (|gated));

   always_comb begin
      case (state)
         dsph_pkg::ST_RUN: begin
            next_state = (sleep_cmd && !(|gated)) ? dsph_pkg::ST_ENTER : dsph_pkg::ST_RUN;
         end
         dsph_pkg::ST_ENTER: begin
            next_state = dsph_pkg::ST_SLEEP;
         end
         dsph_pkg::ST_SLEEP: begin
            next_state = wake_evt ? dsph_pkg::ST_WAKE : dsph_pkg::ST_SLEEP;
         end
         dsph_pkg::ST_WAKE: begin
            next_state = (hold_cnt == HOLD_MAX) ? dsph_pkg::ST_RUN : dsph_pkg::ST_WAKE;
         end
         default: begin
            next_state = dsph_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= dsph_pkg::ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Core reset is held for the power-on hold time after any wake.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hold_cnt     <= 8'h00;
         core_reset_o <= 1'b0;
      end else begin
         hold_cnt     <= (state == dsph_pkg::ST_WAKE) ? hold_cnt + 8'h01 : 8'h00;
         core_reset_o <= next_state == dsph_pkg::ST_WAKE;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         core_vector_o <= 1'b0;
         entry_abort_o <= 1'b0;
      end else begin
         core_vector_o <= abort_evt && core_int_en_i;
         entry_abort_o <= abort_evt && !core_int_en_i;
      end
   end

   // Holding latches are loaded once, at entry, from the live registers.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hold_dir <= '1;
         hold_lat <= '0;
      end else if (entry_done) begin
         hold_dir <= dir[N_PINS-1:0];
         hold_lat <= lat[N_PINS-1:0];
      end
   end

   // Control: the release bit doubles as the freeze flag.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl <= dsph_pkg::CTRL_RST;
      end else begin
         if (reg_wr_i && reg_addr_i == dsph_pkg::OFS_CTRL) begin
            ctrl[dsph_pkg::CTRL_BOR_EN_BIT] <= reg_wdata_i[dsph_pkg::CTRL_BOR_EN_BIT];
         end
         if (entry_done) begin
            ctrl[dsph_pkg::CTRL_RELEASE_BIT] <= 1'b1;
         end else if (state == dsph_pkg::ST_SLEEP && (bor_evt || ext_rst_evt)) begin
            ctrl[dsph_pkg::CTRL_RELEASE_BIT] <= 1'b0;
         end else if (release_clr && state != dsph_pkg::ST_SLEEP) begin
            ctrl[dsph_pkg::CTRL_RELEASE_BIT] <= 1'b0;
         end
      end
   end

   // Wake logs: cleared at entry, one source logged at wake; on a tie brown-out wins, then the external reset pin, then the lowest gated index.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_lo <= dsph_pkg::ZERO_RST;
         wake_hi <= dsph_pkg::ZERO_RST;
      end else if (entry_done) begin
         wake_lo <= dsph_pkg::ZERO_RST;
         wake_hi <= dsph_pkg::ZERO_RST;
      end else if (wake_evt) begin
         if (bor_evt) begin
            wake_lo <= 8'(1 << dsph_pkg::WK_BROWNOUT);
         end else if (ext_rst_evt) begin
            wake_lo <= 8'(1 << dsph_pkg::WK_EXT_RESET);
         end else if (gated[dsph_pkg::EN_CALENDAR]) begin
            wake_lo <= 8'(1 << dsph_pkg::WK_CALENDAR);
         end else if (gated[dsph_pkg::EN_EXTERNAL_INTERRUPT_ZERO]) begin
            wake_hi <= 8'(1 << dsph_pkg::WKH_EXTERNAL_INTERRUPT_ZERO);
         end else if (gated[dsph_pkg::EN_WATCHDOG]) begin
            wake_lo <= 8'(1 << dsph_pkg::WK_WATCHDOG);
         end else begin
            wake_lo <= 8'(1 << dsph_pkg::WK_ULP);
         end
      end
   end

   // Exit flag: set by a deep sleep exit other than by brown-out, cleared only by a firmware write of zero.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wdt_ctrl <= dsph_pkg::ZERO_RST;
      end else if (wake_evt && !bor_evt) begin
         wdt_ctrl[dsph_pkg::WDT_EXIT_BIT] <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == dsph_pkg::OFS_WDT_CTRL) begin
         wdt_ctrl[dsph_pkg::WDT_EXIT_BIT] <= reg_wdata_i[dsph_pkg::WDT_EXIT_BIT];
      end
   end

   // Scratch registers survive everything but a brown-out.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scr0 <= dsph_pkg::ZERO_RST;
         scr1 <= dsph_pkg::ZERO_RST;
      end else if (wake_evt && bor_evt) begin
         scr0 <= dsph_pkg::ZERO_RST;
         scr1 <= dsph_pkg::ZERO_RST;
      end else if (reg_wr_i && reg_addr_i == dsph_pkg::OFS_SCR0) begin
         scr0 <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == dsph_pkg::OFS_SCR1) begin
         scr1 <= reg_wdata_i;
      end
   end

   // Direction and latch return to reset values during the wake reset.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dir <= dsph_pkg::DIR_RST;
         lat <= dsph_pkg::LAT_RST;
      end else if (state == dsph_pkg::ST_WAKE) begin
         dir <= dsph_pkg::DIR_RST;
         lat <= dsph_pkg::LAT_RST;
      end else if (reg_wr_i && reg_addr_i == dsph_pkg::OFS_DIR) begin
         dir <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == dsph_pkg::OFS_LAT) begin
         lat <= reg_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_en  <= dsph_pkg::WAKE_EN_RST;
         irq_mask <= dsph_pkg::ZERO_RST;
      end else begin
         if (reg_wr_i && reg_addr_i == dsph_pkg::OFS_WAKE_EN) begin
            wake_en <= reg_wdata_i;
         end
         if (reg_wr_i && reg_addr_i == dsph_pkg::OFS_IRQ_MASK) begin
            irq_mask <= reg_wdata_i;
         end
      end
   end

   // Sticky interrupt status; a read clears it, but a same-cycle event still sets.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_stat <= dsph_pkg::ZERO_RST;
      end else begin
         irq_stat <= ((reg_rd_i && reg_addr_i == dsph_pkg::OFS_IRQ_STAT) ? 8'h00 : irq_stat)
                     | 8'({7'h00, wake_evt} << dsph_pkg::IRQ_WAKE)
                     | 8'({7'h00, abort_evt} << dsph_pkg::IRQ_ABORT)
                     | 8'({7'h00, wake_evt && bor_evt} << dsph_pkg::IRQ_BOR);
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr_i)
         dsph_pkg::OFS_CTRL:     next_rdata = ctrl;
         dsph_pkg::OFS_WAKE_LO:  next_rdata = wake_lo;
         dsph_pkg::OFS_WAKE_HI:  next_rdata = wake_hi;
         dsph_pkg::OFS_WDT_CTRL: next_rdata = wdt_ctrl;
         dsph_pkg::OFS_SCR0:     next_rdata = scr0;
         dsph_pkg::OFS_SCR1:     next_rdata = scr1;
         dsph_pkg::OFS_DIR:      next_rdata = dir;
         dsph_pkg::OFS_LAT:      next_rdata = lat;
         dsph_pkg::OFS_PIN_IN:   next_rdata = 8'(pin_sync);
         dsph_pkg::OFS_WAKE_EN:  next_rdata = wake_en;
         dsph_pkg::OFS_IRQ_STAT: next_rdata = irq_stat;
         dsph_pkg::OFS_IRQ_MASK: next_rdata = irq_mask;
         default:                next_rdata = 8'h00;
      endcase
   end

   // Read data stand for exactly the cycle after the strobe.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
      end
   end

   dsph_pin_hold #(
      .N_PINS (N_PINS)
   ) u_pin_hold (
      .frozen_i   (frozen),
      .hold_dir_i (hold_dir),
      .hold_lat_i (hold_lat),
      .dir_i      (dir[N_PINS-1:0]),
      .lat_i      (lat[N_PINS-1:0]),
      .next_out_o (next_out),
      .next_oe_o  (next_oe)
   );

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_out_o <= '0;
         pin_oe_o  <= '0;
      end else begin
         pin_out_o <= next_out;
         pin_oe_o  <= next_oe;
      end
   end

endmodule // dsph_top

// >>> bench/dsph_sva.sv
// Port-level assertions for the deep sleep pin hold and wake block.
module dsph_sva #(
   parameter int unsigned N_PINS = 8
) (
   input wire logic              ref_clk_i,     // Block clock.
   input wire logic              arst_n_i,      // Reset, active low.
   input wire logic              reg_wr_i,      // Write strobe.
   input wire logic              reg_rd_i,      // Read strobe.
   input wire logic [7:0]        reg_rdata_o,   // Read data.
   input wire logic              core_int_en_i, // Core interrupt enable.
   input wire logic [N_PINS-1:0] pin_out_o,     // Pin levels.
   input wire logic [N_PINS-1:0] pin_oe_o,      // Pin enables.
   input wire logic              core_reset_o,  // Core reset.
   input wire logic              core_vector_o, // Vector pulse.
   input wire logic              entry_abort_o  // Abort pulse.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [5:0] por_cnt;
   // Counts the cycles of the current core reset so its length can be judged when it ends.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) por_cnt <= 6'h00;
      else por_cnt <= core_reset_o ? por_cnt + 6'h01 : 6'h00;
   end
   chk_por_length: assert property ($fell(core_reset_o) |-> 32'(por_cnt) == 25)
      else $error("core reset length wrong");
   chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside read slot");
   chk_refuse_excl: assert property (!(core_vector_o && entry_abort_o))
      else $error("vector and abort together");
   chk_refuse_pulse: assert property ((core_vector_o || entry_abort_o) |=>
      !(core_vector_o || entry_abort_o)) else $error("refusal pulse too long");
   chk_undriven_low: assert property ((pin_out_o & ~pin_oe_o) == '0)
      else $error("undriven pin shows a level");
   chk_pins_still: assert property (core_reset_o && $past(core_reset_o, 4) |->
      $stable(pin_oe_o) && $stable(pin_out_o)) else $error("pins moved during core reset");
   chk_abort_cause: assert property (entry_abort_o |-> !core_int_en_i &&
      ($past(reg_wr_i) || $past(reg_wr_i, 2))) else $error("abort without cause");
   chk_vector_cause: assert property (core_vector_o |-> $past(core_int_en_i))
      else $error("vector without interrupt enable");
endmodule // dsph_sva

// >>> bench/dsph_wake_src.sv
// Wake sources and external reset pin outside the block.
module dsph_wake_src (
   input  wire logic       ref_clk_i,    // Clock.
   input  wire logic       arst_n_i,     // Reset, active low.
   input  wire logic [5:0] req_i,        // Raise: 0 reset pin, 1 cal, 2 external_interrupt_zero, 3 wdt, 4 ulp, 5 bor.
   input  wire logic       clr_i,        // Drop all sources.
   input  wire logic       core_reset_i, // Core restart.
   output logic      [5:0] src_o         // Source levels.
);
   timeunit 1ns;
   timeprecision 1ps;
   // A source holds its level until serviced, so a slow wake still sees it.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) src_o <= 6'h00;
      else if (clr_i || core_reset_i) src_o <= 6'h00;
      else src_o <= src_o | req_i;
   end
endmodule // dsph_wake_src

// >>> bench/testbench.sv
// Self-checking bench for the deep sleep pin hold and wake block.
`define CMP(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       int_en = 1'b0;
   logic [5:0] req = 6'h00;
   logic       clr = 1'b0;
   logic [5:0] src;
   logic [7:0] rdata, pout, poe;
   logic       crst, vec, abt, irq;
   int         num_errors = 0;
   int         checks = 0;
   int         n;
   always #2 clk = ~clk;
   dsph_wake_src dsph_wake_src_inst (.ref_clk_i(clk), .arst_n_i(rst_n), .req_i(req),
      .clr_i(clr), .core_reset_i(crst), .src_o(src));
   dsph_top #(.N_PINS(8)) dsph_top_inst (.ref_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .ext_reset_n_i(~src[0]), .calendar_alarm_i(src[1]), .ext_int_zero_i(src[2]),
      .watchdog_i(src[3]), .ulp_wake_i(src[4]), .brownout_i(src[5]), .core_int_en_i(int_en),
      .pin_in_i(8'h3C), .pin_out_o(pout), .pin_oe_o(poe), .core_reset_o(crst),
      .core_vector_o(vec), .entry_abort_o(abt), .irq_o(irq));
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CMP("rdata", e, rdata)
   endtask
   task automatic pulse(input logic [5:0] r);
      @(posedge clk);
      req <= r;
      @(posedge clk);
      req <= 6'h00;
   endtask
   task automatic sleep_wake(input logic [7:0] ctrl, input logic [5:0] r);
      wr_reg(4'h0, ctrl);
      repeat (4) @(negedge clk);
      rd_chk(4'h1, 8'h00);
      pulse(r);
      for (n = 0; n < 40 && crst !== 1'b1; n++) @(negedge clk);
      `CMP("core_reset", 1'b1, crst)
      for (n = 0; n < 40 && crst === 1'b1; n++) @(negedge clk);
      repeat (2) @(negedge clk);
   endtask
   task automatic sc_freeze();
      rd_chk(4'h6, 8'hFF);
      rd_chk(4'hC, 8'h00);
      rd_chk(4'h8, 8'h3C);
      wr_reg(4'h6, 8'h0F);
      wr_reg(4'h7, 8'hA5);
      wr_reg(4'hB, 8'h01);
      wr_reg(4'h9, 8'h03);
      sleep_wake(8'h04, 6'h06);
      rd_chk(4'h1, 8'h02);
      rd_chk(4'h2, 8'h00);
      rd_chk(4'h3, 8'h08);
      rd_chk(4'h7, 8'h00);
      `CMP("irq", 1'b1, irq)
      rd_chk(4'hA, 8'h01);
      repeat (2) @(negedge clk);
      `CMP("irq", 1'b0, irq)
      wr_reg(4'h6, 8'h00);
      wr_reg(4'h7, 8'h3C);
      `CMP("pin_oe", 8'hF0, poe)
      `CMP("pin_out", 8'hA0, pout)
      wr_reg(4'h0, 8'h00);
      repeat (3) @(negedge clk);
      `CMP("pin_oe", 8'hFF, poe)
      `CMP("pin_out", 8'h3C, pout)
      wr_reg(4'h3, 8'h00);
      rd_chk(4'h3, 8'h00);
   endtask
   task automatic sc_ext_bor();
      wr_reg(4'h4, 8'h5A);
      wr_reg(4'h5, 8'hC3);
      sleep_wake(8'h04, 6'h01);
      `CMP("pin_oe", 8'h00, poe)
      rd_chk(4'h4, 8'h5A);
      rd_chk(4'h1, 8'h01);
      wr_reg(4'h6, 8'h00);
      sleep_wake(8'h06, 6'h20);
      `CMP("pin_oe", 8'h00, poe)
      rd_chk(4'h5, 8'h00);
      rd_chk(4'h1, 8'h10);
      rd_chk(4'hA, 8'h05);
   endtask
   task automatic sc_abort();
      int a;
      int v;
      wr_reg(4'hB, 8'h02);
      pulse(6'h02);
      // The source needs four edges through the synchroniser before entry may see it.
      repeat (4) @(posedge clk);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         int_en <= i[0];
         wr_reg(4'h0, 8'h04);
         a = 0;
         v = 0;
         repeat (4) begin
            @(negedge clk);
            a += abt;
            v += vec;
         end
         `CMP("abort_pulses", 1 - i, a)
         `CMP("vector_pulses", i, v)
      end
      rd_chk(4'h1, 8'h10);
      `CMP("irq", 1'b1, irq)
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("num_errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      sc_freeze();
      sc_ext_bor();
      sc_abort();
      wrap_up();
   end
   // Far above the few hundred cycles that the sequence needs.
   initial begin
      #20000;
      num_errors++;
      wrap_up();
   end
endmodule // testbench
bind dsph_top dsph_sva #(.N_PINS(N_PINS)) dsph_sva_inst (.ref_clk_i, .arst_n_i, .reg_wr_i,
   .reg_rd_i, .reg_rdata_o, .core_int_en_i, .pin_out_o, .pin_oe_o, .core_reset_o,
   .core_vector_o, .entry_abort_o);
